// *** fchg_pkg.sv ***
// Package of constants and types for the fault capture and hardware register gate
`default_nettype none
package fchg_pkg;
    // ************************************************************
    // Hardware register numbers
    // ************************************************************
    localparam logic [4:0] HWR_CPU_NUMBER   = 5'h00;
    localparam logic [4:0] HWR_SYNCI_STEP   = 5'h01;
    localparam logic [4:0] HWR_CYCLE_COUNT  = 5'h02;
    localparam logic [4:0] HWR_CYCLE_RES    = 5'h03;
    localparam logic [4:0] HWR_PERF_PAIR    = 5'h04;
    localparam logic [4:0] HWR_PAIRED_LLSC  = 5'h05;
    localparam logic [4:0] HWR_RSVD_LO      = 5'h06;
    localparam logic [4:0] HWR_RSVD_HI      = 5'h1c;
    localparam logic [4:0] HWR_USER_LOCAL   = 5'h1d;
    localparam logic [4:0] HWR_IMPL_30      = 5'h1e;
    localparam logic [4:0] HWR_IMPL_31      = 5'h1f;
    // ************************************************************
    // Reset values and field layouts
    // ************************************************************
    localparam logic [31:0] ENABLE_RESET    = 32'h0000_0000;
    localparam logic [31:0] ZERO_WORD       = 32'h0000_0000;
    localparam int          CPU_NUM_W       = 10;
    localparam int          HALF_W          = 16;
    localparam logic [1:0]  ISA_MODE_EXT    = 2'h3;
    // Instruction widths reported by the pipeline
    typedef enum logic [1:0] {
        FCHG_INSTR_16,
        FCHG_INSTR_32,
        FCHG_INSTR_48
    } fchg_instr_width_t;
endpackage : fchg_pkg
`default_nettype wire

// *** fchg_hwr_dec.sv ***
// Decode of hardware register number into an implemented flag
`default_nettype none
module fchg_hwr_dec #(
    parameter logic IMPL_USER_LOCAL = 1'b1,
    parameter logic [1:0] IMPL_TOP  = 2'h0
) (
    input  wire logic [4:0]  reg_num,
    output logic             implemented
);
    always_comb begin
        if (reg_num >= fchg_pkg::HWR_RSVD_LO && reg_num <= fchg_pkg::HWR_RSVD_HI) begin
            implemented = 1'b0;
        end else if (reg_num == fchg_pkg::HWR_USER_LOCAL) begin
            implemented = IMPL_USER_LOCAL;
        end else if (reg_num == fchg_pkg::HWR_IMPL_30) begin
            implemented = IMPL_TOP[0];
        end else if (reg_num == fchg_pkg::HWR_IMPL_31) begin
            implemented = IMPL_TOP[1];
        end else begin
            implemented = 1'b1;
        end
    end
endmodule // fchg_hwr_dec
`default_nettype wire

// *** fchg_capture_reg.sv ***
// Capture register that loads a word on a strobe
`default_nettype none
module fchg_capture_reg (
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        load,
    input  wire logic [31:0] din,
    output logic      [31:0] dout
);
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dout <= fchg_pkg::ZERO_WORD;
        end else if (load) begin
            dout <= din;
        end
    end
endmodule // fchg_capture_reg
`default_nettype wire

// *** fchg_gate.sv ***
// Fault capture registers and user hardware register read gate
`default_nettype none
module fchg_gate #(
    parameter logic       IMPL_USER_LOCAL = 1'b1,
    parameter logic [1:0] IMPL_TOP        = 2'h0,
    parameter logic [31:0] SYNCI_STEP     = 32'h0000_0020,
    parameter logic [31:0] CYCLE_RES      = 32'h0000_0001,
    parameter logic [31:0] PAIRED_LLSC    = 32'h0000_0000,
    parameter logic [31:0] IMPL_30_VALUE  = 32'h0000_0000,
    parameter logic [31:0] IMPL_31_VALUE  = 32'h0000_0000
) (
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // Configuration
    input  wire logic [1:0]  isa_mode_field,
    input  wire logic        no_user_hwreg_option,
    output logic             fault_instr_present_bit,
    output logic             prior_branch_present_bit,
    // Privileged mask access
    input  wire logic        enable_wr,
    input  wire logic [31:0] enable_wdata,
    output logic      [31:0] hw_reg_user_enable_mask,
    // Sources for user reads
    input  wire logic [31:0] exception_base_register,
    input  wire logic [31:0] cycle_count,
    input  wire logic [31:0] perf_control,
    input  wire logic [31:0] perf_counter,
    input  wire logic [31:0] user_local_register,
    // User hardware register read
    input  wire logic        rdhw_valid,
    input  wire logic [4:0]  rdhw_num,
    input  wire logic [2:0]  rdhw_sel,
    input  wire logic        cp0_rights,
    output logic             rdhw_done,
    output logic      [31:0] rdhw_data,
    output logic             reserved_instr_exc,
    // Exception commit
    input  wire logic        exc_commit,
    input  wire logic        exc_addr_class,
    input  wire logic        exc_instr_sync,
    input  wire logic [31:0] exc_vaddr,
    input  wire logic [31:0] exc_instr,
    input  wire logic [15:0] exc_instr_low,
    input  wire fchg_pkg::fchg_instr_width_t exc_width,
    input  wire logic        exc_in_delay_slot,
    input  wire logic [31:0] exc_branch_instr,
    output logic      [31:0] fault_virtual_address,
    output logic      [31:0] faulting_instruction_word,
    output logic      [31:0] faulting_instruction_extension,
    output logic      [31:0] prior_branch_instruction
);
    // ************************************************************
    // Configuration bits
    // ************************************************************
    logic        mask_off;
    logic [31:0] impl_mask;
    logic [31:0] enable_store;
    logic        target_impl;
    logic        next_exc;
    logic [31:0] next_data;
    logic [31:0] instr_fill;
    logic        load_addr;
    logic        load_instr;
    logic        load_ext;
    logic        load_branch;

    assign mask_off = (isa_mode_field == fchg_pkg::ISA_MODE_EXT) && no_user_hwreg_option;
    assign fault_instr_present_bit  = ~no_user_hwreg_option;
    assign prior_branch_present_bit = (isa_mode_field < fchg_pkg::ISA_MODE_EXT);

    // ************************************************************
    // Implemented-register mask
    // ************************************************************
    // One decoder per mask bit keeps write masking and read gating consistent
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++) begin : g_impl
            fchg_hwr_dec #(
                .IMPL_USER_LOCAL(IMPL_USER_LOCAL),
                .IMPL_TOP       (IMPL_TOP)
            ) u_dec (
                .reg_num    (5'(gi)),
                .implemented(impl_mask[gi])
            );
        end
    endgenerate

    fchg_hwr_dec #(
        .IMPL_USER_LOCAL(IMPL_USER_LOCAL),
        .IMPL_TOP       (IMPL_TOP)
    ) u_target_dec (
        .reg_num    (rdhw_num),
        .implemented(target_impl)
    );

    // ************************************************************
    // User enable mask
    // ************************************************************
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            enable_store <= fchg_pkg::ENABLE_RESET;
        end else if (enable_wr && !mask_off) begin
            enable_store <= enable_wdata & impl_mask;
        end
    end

    // Option bit may change later; read view forced to zero while it holds in the extended ISA mode
    assign hw_reg_user_enable_mask = mask_off ? fchg_pkg::ZERO_WORD : enable_store;

    // ************************************************************
    // User read path
    // ************************************************************
    always_comb begin
        next_data = fchg_pkg::ZERO_WORD;
        unique case (rdhw_num)
            fchg_pkg::HWR_CPU_NUMBER: next_data = 32'(exception_base_register[fchg_pkg::CPU_NUM_W-1:0]);
            fchg_pkg::HWR_SYNCI_STEP: next_data = SYNCI_STEP;
            fchg_pkg::HWR_CYCLE_COUNT: next_data = cycle_count;
            fchg_pkg::HWR_CYCLE_RES: next_data = CYCLE_RES;
            fchg_pkg::HWR_PERF_PAIR: next_data = rdhw_sel[0] ? perf_counter : perf_control;
            fchg_pkg::HWR_PAIRED_LLSC: next_data = PAIRED_LLSC;
            fchg_pkg::HWR_USER_LOCAL: next_data = user_local_register;
            fchg_pkg::HWR_IMPL_30: next_data = IMPL_30_VALUE;
            fchg_pkg::HWR_IMPL_31: next_data = IMPL_31_VALUE;
            default: next_data = fchg_pkg::ZERO_WORD;
        endcase
    end

    // Unimplemented numbers fault even with privilege; no emulation target exists
    assign next_exc = !target_impl ||
                      (!cp0_rights && !hw_reg_user_enable_mask[rdhw_num]);

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdhw_done          <= 1'b0;
            reserved_instr_exc <= 1'b0;
        end else begin
            rdhw_done          <= rdhw_valid;
            reserved_instr_exc <= rdhw_valid && next_exc;
        end
    end

    // Data withheld on a fault so denied values never leak
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdhw_data <= fchg_pkg::ZERO_WORD;
        end else if (rdhw_valid) begin
            rdhw_data <= next_exc ? fchg_pkg::ZERO_WORD : next_data;
        end
    end

    // ************************************************************
    // Fault capture
    // ************************************************************
    // Pipeline presents the faulting part's own address on split accesses
    assign load_addr   = exc_commit && exc_addr_class;
    assign load_instr  = exc_commit && exc_instr_sync;
    assign load_ext    = load_instr && (exc_width == fchg_pkg::FCHG_INSTR_48);
    // Loaded only in a delay slot; outside one the content is unpredictable and the old value is kept
    assign load_branch = load_instr && exc_in_delay_slot;

    // Word taken as given even when invalid; value then unpredictable
    always_comb begin
        unique case (exc_width)
            fchg_pkg::FCHG_INSTR_16: instr_fill = {exc_instr[fchg_pkg::HALF_W-1:0], 16'h0000};
            default: instr_fill = exc_instr;
        endcase
    end

    fchg_capture_reg u_addr (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .load   (load_addr),
        .din    (exc_vaddr),
        .dout   (fault_virtual_address)
    );

    fchg_capture_reg u_instr (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .load   (load_instr),
        .din    (instr_fill),
        .dout   (faulting_instruction_word)
    );

    fchg_capture_reg u_ext (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .load   (load_ext),
        .din    ({exc_instr_low, 16'h0000}),
        .dout   (faulting_instruction_extension)
    );

    fchg_capture_reg u_branch (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .load   (load_branch),
        .din    (exc_branch_instr),
        .dout   (prior_branch_instruction)
    );

    // ************************************************************
    // Assertions
    // ************************************************************
    sequence s_denied_read;
        rdhw_valid && target_impl && !cp0_rights && !hw_reg_user_enable_mask[rdhw_num];
    endsequence

    a_denied_read_fault: assert property (@(posedge sys_clk) disable iff (sys_rst)
        s_denied_read |=> reserved_instr_exc && rdhw_done)
        else $error("denied user read did not fault");
    a_enabled_read_ok: assert property (@(posedge sys_clk) disable iff (sys_rst)
        rdhw_valid && target_impl && hw_reg_user_enable_mask[rdhw_num] |=> !reserved_instr_exc)
        else $error("enabled user read faulted");
    a_reserved_num_fault: assert property (@(posedge sys_clk) disable iff (sys_rst)
        rdhw_valid && rdhw_num >= fchg_pkg::HWR_RSVD_LO && rdhw_num <= fchg_pkg::HWR_RSVD_HI
        |=> reserved_instr_exc)
        else $error("reserved number did not fault");
    a_mask_unimpl_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (hw_reg_user_enable_mask & ~impl_mask) == fchg_pkg::ZERO_WORD)
        else $error("unimplemented mask bit set");
    a_mask_off_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
        mask_off |-> hw_reg_user_enable_mask == fchg_pkg::ZERO_WORD)
        else $error("disabled mask reads nonzero");
    a_cycle_count_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
        rdhw_valid && rdhw_num == fchg_pkg::HWR_CYCLE_COUNT && !next_exc |=> rdhw_data == $past(cycle_count))
        else $error("cycle counter read wrong");
    a_perf_half_select: assert property (@(posedge sys_clk) disable iff (sys_rst)
        rdhw_valid && rdhw_num == fchg_pkg::HWR_PERF_PAIR && !next_exc && rdhw_sel[0]
        |=> rdhw_data == $past(perf_counter))
        else $error("perf counter half wrong");
    a_addr_capture: assert property (@(posedge sys_clk) disable iff (sys_rst)
        load_addr |=> fault_virtual_address == $past(exc_vaddr))
        else $error("fault address not captured");
    a_instr_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
        exc_commit && !exc_instr_sync |=> $stable(faulting_instruction_word))
        else $error("async exception changed instruction capture");
    a_half_instr_place: assert property (@(posedge sys_clk) disable iff (sys_rst)
        load_instr && exc_width == fchg_pkg::FCHG_INSTR_16
        |=> faulting_instruction_word[31:16] == $past(exc_instr[15:0]))
        else $error("16-bit instruction misplaced");
    a_ext_low_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
        load_ext |=> faulting_instruction_extension == {$past(exc_instr_low), 16'h0000})
        else $error("extension capture wrong");
    a_branch_capture: assert property (@(posedge sys_clk) disable iff (sys_rst)
        load_branch |=> prior_branch_instruction == $past(exc_branch_instr))
        else $error("prior branch not captured");
    a_cpu_num_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
        rdhw_valid && rdhw_num == fchg_pkg::HWR_CPU_NUMBER && !next_exc
        |=> rdhw_data == 32'($past(exception_base_register[fchg_pkg::CPU_NUM_W-1:0])))
        else $error("cpu number read wrong");
    a_cycle_res_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
        rdhw_valid && rdhw_num == fchg_pkg::HWR_CYCLE_RES && !next_exc |=> rdhw_data == CYCLE_RES)
        else $error("cycle counter resolution read wrong");
    a_user_local_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
        rdhw_valid && rdhw_num == fchg_pkg::HWR_USER_LOCAL && !next_exc
        |=> rdhw_data == $past(user_local_register))
        else $error("user local read wrong");
    a_impl_top_fault: assert property (@(posedge sys_clk) disable iff (sys_rst)
        rdhw_valid && rdhw_num >= fchg_pkg::HWR_IMPL_30 && !IMPL_TOP[rdhw_num[0]] |=> reserved_instr_exc)
        else $error("absent top register did not fault");
    a_impl_top_mask: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (hw_reg_user_enable_mask[fchg_pkg::HWR_IMPL_31:fchg_pkg::HWR_IMPL_30] & ~IMPL_TOP) == 2'h0)
        else $error("absent top mask bit set");
    a_rsvd_bits_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
        hw_reg_user_enable_mask[fchg_pkg::HWR_RSVD_HI:fchg_pkg::HWR_RSVD_LO] == '0)
        else $error("reserved mask bit set");
    a_mask_wr_ignored: assert property (@(posedge sys_clk) disable iff (sys_rst)
        mask_off |=> enable_store == $past(enable_store))
        else $error("mask written while switched off");
    a_full_instr_place: assert property (@(posedge sys_clk) disable iff (sys_rst)
        load_instr && exc_width != fchg_pkg::FCHG_INSTR_16
        |=> faulting_instruction_word == $past(exc_instr))
        else $error("full instruction capture wrong");
    a_done_pulse: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !rdhw_valid |=> !rdhw_done && !reserved_instr_exc)
        else $error("read answer without request");
    a_data_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !rdhw_valid |=> $stable(rdhw_data))
        else $error("read data changed without request");
endmodule // fchg_gate
`default_nettype wire

// *** fchg_pipe_model.sv ***
// Pipeline-side model supplying the source values behind user hardware register reads
`default_nettype none
module fchg_pipe_model (
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    output logic      [31:0] cycle_count,
    output logic      [31:0] exception_base_register,
    output logic      [31:0] perf_control,
    output logic      [31:0] perf_counter,
    output logic      [31:0] user_local_register
);
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************************
    // Free-running counter, one step per cycle
    // ************************************************************
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cycle_count <= 32'h0000_0100;
        end else begin
            cycle_count <= cycle_count + 32'h0000_0001;
        end
    end
    // Upper bits set so that leaking them past the cpu number shows up
    assign exception_base_register = 32'h8000_0155;
    assign perf_control            = 32'h0000_0a0f;
    assign perf_counter            = 32'h1234_5678;
    assign user_local_register     = 32'hcafe_0042;
endmodule // fchg_pipe_model
`default_nettype wire

// *** tb_fault_capture_hwreg_gate.sv ***
// Self-checking testbench for the fault capture and hardware register gate
`default_nettype none
module tb_fault_capture_hwreg_gate;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk, sys_rst, no_user_hwreg_option, enable_wr, rdhw_valid, cp0_rights;
    logic        exc_commit, exc_addr_class, exc_instr_sync, exc_in_delay_slot;
    logic        fault_instr_present_bit, prior_branch_present_bit, rdhw_done, reserved_instr_exc;
    logic [1:0]  isa_mode_field;
    logic [4:0]  rdhw_num;
    logic [2:0]  rdhw_sel;
    logic [15:0] exc_instr_low;
    logic [31:0] enable_wdata, exc_vaddr, exc_instr, exc_branch_instr, hw_reg_user_enable_mask, rdhw_data;
    logic [31:0] fault_virtual_address, faulting_instruction_word, faulting_instruction_extension;
    logic [31:0] prior_branch_instruction, cycle_count, exception_base_register, perf_control;
    logic [31:0] perf_counter, user_local_register, mask_exp, fva_e, fiw_e, fie_e, pbi_e;
    fchg_pkg::fchg_instr_width_t exc_width;
    int          miscompares, total_checks, cycles;

    fchg_gate i_dut (.sys_clk, .sys_rst, .isa_mode_field, .no_user_hwreg_option, .fault_instr_present_bit,
        .prior_branch_present_bit, .enable_wr, .enable_wdata, .hw_reg_user_enable_mask,
        .exception_base_register, .cycle_count, .perf_control, .perf_counter, .user_local_register,
        .rdhw_valid, .rdhw_num, .rdhw_sel, .cp0_rights, .rdhw_done, .rdhw_data, .reserved_instr_exc,
        .exc_commit, .exc_addr_class, .exc_instr_sync, .exc_vaddr, .exc_instr, .exc_instr_low, .exc_width,
        .exc_in_delay_slot, .exc_branch_instr, .fault_virtual_address, .faulting_instruction_word,
        .faulting_instruction_extension, .prior_branch_instruction);
    fchg_pipe_model i_pipe (.sys_clk, .sys_rst, .cycle_count, .exception_base_register, .perf_control,
        .perf_counter, .user_local_register);

    // ************************************************************
    // Clock, timeout and shared tasks
    // ************************************************************
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles > 2000) begin
            miscompares++;
            final_report();
        end
    end
    task automatic final_report();
        if (miscompares == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Every request starts one edge later, so no signal is assigned twice in a time step
    task automatic step();
        @(posedge sys_clk);
        #1;
    endtask
    function automatic logic [31:0] hw_val(input logic [4:0] n, input logic [2:0] s);
        case (n)
            5'h00: return {22'h0, exception_base_register[9:0]};
            5'h01: return 32'h0000_0020;
            5'h02: return cycle_count;
            5'h03: return 32'h0000_0001;
            5'h04: return s[0] ? perf_counter : perf_control;
            5'h1d: return user_local_register;
            default: return 32'h0000_0000;
        endcase
    endfunction
    task automatic wr(input logic [31:0] d);
        step();
        enable_wr = 1'b1;
        enable_wdata = d;
        mask_exp = (isa_mode_field == 2'h3 && no_user_hwreg_option) ? 32'h0 : d & 32'h2000_003f;
        step();
        enable_wr = 1'b0;
        chk("mask", mask_exp, hw_reg_user_enable_mask);
    endtask
    task automatic rd(input logic [4:0] n, input logic [2:0] s, input logic r);
        logic        x;
        logic [31:0] v;
        step();
        x = !(n <= 5'h05 || n == 5'h1d) || (!r && !mask_exp[n]);
        v = x ? 32'h0 : hw_val(n, s);
        rdhw_valid = 1'b1;
        rdhw_num = n;
        rdhw_sel = s;
        cp0_rights = r;
        step();
        rdhw_valid = 1'b0;
        chk("rdhw_done", 32'h1, {31'h0, rdhw_done});
        chk("reserved_instr_exc", {31'h0, x}, {31'h0, reserved_instr_exc});
        chk("rdhw_data", v, rdhw_data);
    endtask
    task automatic exc(input logic a, input logic y, input fchg_pkg::fchg_instr_width_t w, input logic ds);
        step();
        exc_commit = 1'b1;
        exc_addr_class = a;
        exc_instr_sync = y;
        exc_width = w;
        exc_in_delay_slot = ds;
        exc_vaddr = exc_vaddr + 32'h0000_1ffe;
        exc_instr = exc_instr + 32'h0101_0203;
        exc_instr_low = exc_instr_low + 16'h1111;
        exc_branch_instr = exc_branch_instr + 32'h0011_0022;
        if (a) fva_e = exc_vaddr;
        if (y) begin
            fiw_e = (w == fchg_pkg::FCHG_INSTR_16) ? {exc_instr[15:0], 16'h0} : exc_instr;
            if (w == fchg_pkg::FCHG_INSTR_48) fie_e = {exc_instr_low, 16'h0};
            if (ds) pbi_e = exc_branch_instr;
        end
        step();
        exc_commit = 1'b0;
        chk("fault_va", fva_e, fault_virtual_address);
        chk("instr_word", fiw_e, faulting_instruction_word);
        chk("instr_ext", fie_e, faulting_instruction_extension);
        chk("prior_branch", pbi_e, prior_branch_instruction);
    endtask

    // ************************************************************
    // Test sequence
    // ************************************************************
    initial begin
        {no_user_hwreg_option, enable_wr, rdhw_valid, cp0_rights, exc_commit} = 5'h0;
        {exc_addr_class, exc_instr_sync, exc_in_delay_slot, isa_mode_field} = 5'h0;
        {rdhw_num, rdhw_sel, exc_instr_low, enable_wdata} = 56'h0;
        {exc_vaddr, exc_instr, exc_branch_instr} = 96'h0;
        {fva_e, fiw_e, fie_e, pbi_e, mask_exp} = 160'h0;
        exc_width = fchg_pkg::FCHG_INSTR_32;
        sys_rst = 1'b1;
        repeat (20) @(posedge sys_clk);
        #1;
        sys_rst = 1'b0;
        chk("mask_reset", 32'h0, hw_reg_user_enable_mask);
        // Every mode and option pairing, a full write in each
        for (int m = 0; m < 8; m++) begin
            isa_mode_field = 2'(m >> 1);
            no_user_hwreg_option = m[0];
            wr(32'hffff_ffff);
            chk("instr_present", {31'h0, !m[0]}, {31'h0, fault_instr_present_bit});
            chk("branch_present", {31'h0, (m >> 1) < 3}, {31'h0, prior_branch_present_bit});
        end
        wr(32'h0000_0000);
        isa_mode_field = 2'h0;
        no_user_hwreg_option = 1'b0;
        step();
        chk("mask_kept", 32'h2000_003f, hw_reg_user_enable_mask);
        wr(32'hffff_ffff);
        for (int n = 0; n < 32; n++) rd(5'(n), 3'h0, 1'b0);
        rd(5'h04, 3'h1, 1'b0);
        rd(5'h04, 3'h6, 1'b0);
        wr(32'h0000_0004);
        for (int n = 0; n < 64; n++) rd(5'(n), 3'(n >> 3), n >= 32);
        exc(1'b1, 1'b0, fchg_pkg::FCHG_INSTR_32, 1'b0);
        exc(1'b0, 1'b0, fchg_pkg::FCHG_INSTR_16, 1'b1);
        exc(1'b1, 1'b1, fchg_pkg::FCHG_INSTR_32, 1'b0);
        exc(1'b0, 1'b1, fchg_pkg::FCHG_INSTR_16, 1'b1);
        exc(1'b1, 1'b1, fchg_pkg::FCHG_INSTR_48, 1'b1);
        exc(1'b0, 1'b1, fchg_pkg::FCHG_INSTR_48, 1'b0);
        // Mid-run reset clears captures and mask, then reads work again
        sys_rst = 1'b1;
        step();
        chk("fault_va_reset", 32'h0, fault_virtual_address);
        chk("instr_word_reset", 32'h0, faulting_instruction_word);
        chk("mask_reset_mid", 32'h0, hw_reg_user_enable_mask);
        sys_rst = 1'b0;
        mask_exp = 32'h0;
        rd(5'h02, 3'h0, 1'b1);
        rd(5'h02, 3'h0, 1'b0);
        final_report();
    end
endmodule // tb_fault_capture_hwreg_gate
`default_nettype wire
